// ### hdl/ssp_status_unit.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_status_unit #(
    parameter longint SETTLE_CYCLES = ssp_pkg::SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    // Bus events, already decoded on this clock
    input wire logic ifcClear,
    input wire logic devClear,
    input wire logic clearStatusCmd,
    input wire logic outputStatusCmd,
    input wire logic maskOutputCmd,
    input wire logic maskSetStrobe,
    input wire logic [7:0] maskSetValue,
    input wire logic messageReadDone,
    input wire logic programString,
    input wire logic presetCmd,
    input wire logic settlePending,
    // Talker byte path
    input wire logic talkReady,
    output logic talkValid,
    output logic [7:0] talkData,
    // Serial and parallel poll
    input wire logic serialPollRead,
    output logic [7:0] pollByte,
    input wire logic parallelPoll,
    input wire logic [2:0] ppLine,
    input wire logic ppSense,
    input wire logic ppEnable,
    output logic [7:0] ppDataOut,
    output logic [7:0] ppDataOe_n,
    // Raw conditions from instrument pins
    input wire logic [7:0] stbCondPin,
    input wire logic [7:0] extCondPin,
    input wire logic rfOffPin,
    // Indicators
    output logic srqOut,
    output logic srqOe_n,
    output logic srqLamp,
    output logic extValid,
    output logic [7:0] statusByte,
    output logic [7:0] extendedStatusByte
);
    logic [7:0] stbRise, extLevel;
    logic [0:0] rfOffLvl;
    logic [7:0] stb_q, ext_q, mask_q, frozen_q;
    logic frozenHeld_q, errorMsg_q, resettle_q;
    ssp_pkg::ssp_os_e osState_q;
    logic extRead, stbHit, extAlter;
    logic [7:0] stbSet, extSet;

    if (SETTLE_CYCLES < 1) begin : gBadSettle
        $error("settle count must be positive");
    end

    ssp_pin_sync #(.WIDTH(8)) uStbSync (
        .clk(clk), .rst(rst), .pinIn(stbCondPin),
        .level(), .rise(stbRise));
    ssp_pin_sync #(.WIDTH(8)) uExtSync (
        .clk(clk), .rst(rst), .pinIn(extCondPin),
        .level(extLevel), .rise());
    ssp_pin_sync #(.WIDTH(1)) uRfSync (
        .clk(clk), .rst(rst), .pinIn(rfOffPin),
        .level(rfOffLvl), .rise());
    ssp_settle_timer #(.CYCLES(SETTLE_CYCLES)) uSettle (
        .clk(clk), .rst(rst), .start(devClear), .valid(extValid));

    // Extended read completes when the second byte is taken
    assign extRead = (osState_q == ssp_pkg::SSP_SEND_EXT) && talkReady;
    always_comb begin
        extSet = extLevel & ssp_pkg::EXT_LIVE_MASK;
        if (rfOffLvl[0]) begin
            extSet[ssp_pkg::EXT_LOCKLOST] = 1'b1;
            extSet[ssp_pkg::EXT_LEVELFAULT] = 1'b1;
        end
    end
    // A clear that alters the latched extended byte is reported
    assign extAlter = clearStatusCmd &&
        ((ext_q & ~extSet) != ssp_pkg::BYTE_ZERO);
    always_comb begin
        stbSet = stbRise;
        stbSet[ssp_pkg::STB_RQS] = 1'b0;
        stbSet[ssp_pkg::STB_EXTCHG] = stbRise[ssp_pkg::STB_EXTCHG] ||
            extAlter || ((extSet & ~ext_q) != ssp_pkg::BYTE_ZERO);
        stbSet[ssp_pkg::STB_ERROR] = stbRise[ssp_pkg::STB_ERROR] ||
            (errorMsg_q && programString);
        // Settling outlives a clear, and preset may settle first
        stbSet[ssp_pkg::STB_SETTLED] = stbRise[ssp_pkg::STB_SETTLED] ||
            (resettle_q && !clearStatusCmd) || presetCmd;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_q <= ssp_pkg::BYTE_ZERO;
        end else if (clearStatusCmd || extRead) begin
            ext_q <= extSet;
        end else begin
            ext_q <= ext_q | extSet;
        end
    end

    assign stbHit = ((stb_q & mask_q & ~(8'h01 << ssp_pkg::STB_RQS))
        != ssp_pkg::BYTE_ZERO);
    always_ff @(posedge clk) begin
        if (rst) begin
            stb_q <= ssp_pkg::BYTE_ZERO;
        end else if (clearStatusCmd || extRead) begin
            // New events in the clear cycle still land
            stb_q <= stbSet;
        end else begin
            stb_q <= stb_q | stbSet;
            stb_q[ssp_pkg::STB_RQS] <= stbHit &&
                !(frozenHeld_q && serialPollRead);
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clearStatusCmd || extRead) begin
            frozen_q <= ssp_pkg::BYTE_ZERO;
            frozenHeld_q <= 1'b0;
        end else if (serialPollRead) begin
            frozenHeld_q <= 1'b0;
        end else if (stb_q[ssp_pkg::STB_RQS] && !frozenHeld_q) begin
            frozen_q <= stb_q;
            frozenHeld_q <= 1'b1;
        end
    end
    // Poll sees the frozen copy while held, live otherwise
    assign pollByte = frozenHeld_q ? frozen_q : stb_q;

    always_ff @(posedge clk) begin
        if (rst || ifcClear) begin
            mask_q <= ssp_pkg::BYTE_ZERO;
        end else if (maskSetStrobe) begin
            mask_q <= maskSetValue;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || messageReadDone) begin
            errorMsg_q <= 1'b0;
        end else if (stbRise[ssp_pkg::STB_ERROR]) begin
            errorMsg_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            resettle_q <= 1'b0;
        end else if (clearStatusCmd) begin
            resettle_q <= settlePending;
        end else begin
            resettle_q <= 1'b0;
        end
    end

    // Talker: two raw bytes after output-status, one after mask output
    always_ff @(posedge clk) begin
        if (rst) begin
            osState_q <= ssp_pkg::SSP_IDLE;
            talkData <= ssp_pkg::BYTE_ZERO;
            talkValid <= 1'b0;
        end else begin
            case (osState_q)
                ssp_pkg::SSP_IDLE: begin
                    if (outputStatusCmd) begin
                        osState_q <= ssp_pkg::SSP_SEND_STB;
                        talkData <= stb_q;
                        talkValid <= 1'b1;
                    end else if (maskOutputCmd) begin
                        talkData <= mask_q;
                        talkValid <= 1'b1;
                    end else if (talkReady) begin
                        talkValid <= 1'b0;
                    end
                end
                ssp_pkg::SSP_SEND_STB: begin
                    if (talkReady) begin
                        osState_q <= ssp_pkg::SSP_SEND_EXT;
                        talkData <= ext_q;
                    end
                end
                ssp_pkg::SSP_SEND_EXT: begin
                    if (talkReady) begin
                        osState_q <= ssp_pkg::SSP_IDLE;
                        talkValid <= 1'b0;
                    end
                end
                default: begin
                    osState_q <= ssp_pkg::SSP_IDLE;
                    talkValid <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain service request line: enable low means driven low (true)
    assign srqOut = 1'b0;
    assign srqOe_n = !stb_q[ssp_pkg::STB_RQS];
    assign srqLamp = stb_q[ssp_pkg::STB_RQS];
    genvar g;
    for (g = 0; g < 8; g++) begin : gPp
        // Low-true bus: sense one drives low, sense zero drives high
        assign ppDataOut[g] = !ppSense;
        // Only the assigned line, and only while the request stands
        assign ppDataOe_n[g] = !(parallelPoll && ppEnable &&
            (ppLine == 3'(g)) &&
            stb_q[ssp_pkg::STB_RQS]);
    end
    assign statusByte = stb_q;
    assign extendedStatusByte = ext_q;

    a_mask_reset: assert property (@(posedge clk)
        $past(rst) |-> mask_q == ssp_pkg::BYTE_ZERO)
        else $error("mask not zero after reset");
    a_ifc_zero: assert property (@(posedge clk) disable iff (rst)
        ifcClear |=> mask_q == ssp_pkg::BYTE_ZERO)
        else $error("interface clear kept mask");
    a_srq_gate: assert property (@(posedge clk) disable iff (rst)
        (!stbHit && !clearStatusCmd && !extRead) |=> !srqLamp)
        else $error("request without enabled bit");
    a_srq_line: assert property (@(posedge clk) disable iff (rst)
        srqLamp == !srqOe_n)
        else $error("service line disagrees with flag");
    a_clear_both: assert property (@(posedge clk) disable iff (rst)
        clearStatusCmd |=> (ext_q == $past(extSet)) && !srqLamp)
        else $error("clear did not clear both bytes");
    a_ext_sticky: assert property (@(posedge clk) disable iff (rst)
        (!clearStatusCmd && !extRead) |=> ((ext_q & $past(ext_q))
        == $past(ext_q)))
        else $error("extended bit dropped");
    a_rf_off: assert property (@(posedge clk) disable iff (rst)
        rfOffLvl[0] |=> ext_q[ssp_pkg::EXT_LOCKLOST] &&
        ext_q[ssp_pkg::EXT_LEVELFAULT])
        else $error("rf off flags missing");
    sequence sOsStart;
        outputStatusCmd && osState_q == ssp_pkg::SSP_IDLE;
    endsequence
    a_os_order: assert property (@(posedge clk) disable iff (rst)
        sOsStart |=> talkValid && osState_q == ssp_pkg::SSP_SEND_STB)
        else $error("output status did not start");
    a_poll_keep: assert property (@(posedge clk) disable iff (rst)
        (serialPollRead && !clearStatusCmd && !extRead) |=>
        ((stb_q | (8'h01 << ssp_pkg::STB_RQS)) & $past(stb_q))
        == $past(stb_q))
        else $error("serial poll cleared a bit");

    sequence sPollRelease;
        frozenHeld_q && serialPollRead && !clearStatusCmd && !extRead;
    endsequence
    sequence sClearPending;
        clearStatusCmd && settlePending;
    endsequence

    // Poll copy is taken once and held until a poll, a clear or an extended read releases it
    a_freeze_take: assert property (@(posedge clk) disable iff (rst)
        (srqLamp && !frozenHeld_q && !serialPollRead && !clearStatusCmd &&
        !extRead) |=> frozenHeld_q && (frozen_q == $past(stb_q)))
        else $error("poll copy not frozen");
    a_frozen_hold: assert property (@(posedge clk) disable iff (rst)
        (frozenHeld_q && !serialPollRead && !clearStatusCmd && !extRead)
        |=> frozenHeld_q && $stable(frozen_q))
        else $error("poll copy changed while held");
    a_poll_drop: assert property (@(posedge clk) disable iff (rst)
        sPollRelease
        |=> !srqLamp && !frozenHeld_q)
        else $error("poll did not release the copy");
    a_poll_again: assert property (@(posedge clk) disable iff (rst)
        sPollRelease ##1 (stbHit && !clearStatusCmd && !extRead)
        |=> srqLamp)
        else $error("pending bit did not request again");
    a_os_live: assert property (@(posedge clk) disable iff (rst)
        sOsStart
        |=> talkData == $past(stb_q))
        else $error("output status not live");
    a_os_second: assert property (@(posedge clk) disable iff (rst)
        (osState_q == ssp_pkg::SSP_SEND_STB && talkReady)
        |=> osState_q == ssp_pkg::SSP_SEND_EXT && talkData == $past(ext_q))
        else $error("extended byte not second");
    a_os_done: assert property (@(posedge clk) disable iff (rst)
        extRead
        |=> osState_q == ssp_pkg::SSP_IDLE && !talkValid)
        else $error("talker did not finish");
    a_ext_read: assert property (@(posedge clk) disable iff (rst)
        extRead
        |=> ext_q == $past(extSet))
        else $error("extended read did not clear");
    a_read_drop: assert property (@(posedge clk) disable iff (rst)
        extRead
        |=> !srqLamp)
        else $error("request kept after extended read");
    a_talk_hold: assert property (@(posedge clk) disable iff (rst)
        (talkValid && !talkReady && osState_q != ssp_pkg::SSP_IDLE)
        |=> talkValid && $stable(talkData))
        else $error("talker byte not held");

    // Mask changes only by a set, an interface clear or reset
    a_mask_load: assert property (@(posedge clk) disable iff (rst)
        (maskSetStrobe && !ifcClear)
        |=> mask_q == $past(maskSetValue))
        else $error("mask value not taken");
    a_mask_keep: assert property (@(posedge clk) disable iff (rst)
        (!maskSetStrobe && !ifcClear)
        |=> $stable(mask_q))
        else $error("mask changed without a set");
    a_mask_talk: assert property (@(posedge clk) disable iff (rst)
        (maskOutputCmd && !outputStatusCmd &&
        osState_q == ssp_pkg::SSP_IDLE)
        |=> talkValid && talkData == $past(mask_q))
        else $error("mask output wrong");

    a_ext_fixed: assert property (@(posedge clk) disable iff (rst)
        (ext_q & ~ssp_pkg::EXT_LIVE_MASK) == ssp_pkg::BYTE_ZERO)
        else $error("fixed extended bit set");
    a_clear_change: assert property (@(posedge clk) disable iff (rst)
        (clearStatusCmd && ((ext_q & ~extSet) != ssp_pkg::BYTE_ZERO))
        |=> stb_q[ssp_pkg::STB_EXTCHG])
        else $error("altering clear not reported");
    a_stb_sticky: assert property (@(posedge clk) disable iff (rst)
        (!clearStatusCmd && !extRead)
        |=> ((stb_q | (8'h01 << ssp_pkg::STB_RQS)) & $past(stb_q))
        == $past(stb_q))
        else $error("status bit dropped");
    a_preset_set: assert property (@(posedge clk) disable iff (rst)
        presetCmd
        |=> stb_q[ssp_pkg::STB_SETTLED])
        else $error("preset did not set settled");
    a_settle_again: assert property (@(posedge clk) disable iff (rst)
        sClearPending ##1 !clearStatusCmd
        |=> stb_q[ssp_pkg::STB_SETTLED])
        else $error("settled not set after clear");
    a_error_repeat: assert property (@(posedge clk) disable iff (rst)
        (errorMsg_q && programString)
        |=> stb_q[ssp_pkg::STB_ERROR])
        else $error("unread error did not repeat");
    a_valid_drop: assert property (@(posedge clk) disable iff (rst)
        devClear
        |=> !extValid)
        else $error("extended valid too early");

    // Parallel poll answers on one line at most
    a_pp_quiet: assert property (@(posedge clk) disable iff (rst)
        (!parallelPoll || !ppEnable || !srqLamp)
        |-> (&ppDataOe_n))
        else $error("poll line driven without request");
    a_pp_single: assert property (@(posedge clk) disable iff (rst)
        $countones(~ppDataOe_n) <= 1)
        else $error("more than one poll line driven");
    a_pp_level: assert property (@(posedge clk) disable iff (rst)
        !(&ppDataOe_n)
        |-> ppDataOut == {8{!ppSense}})
        else $error("poll line has wrong sense");
endmodule : ssp_status_unit
`default_nettype wire

// ### hdl/ssp_pkg.sv
package ssp_pkg;
    localparam int STB_KEY = 0;
    localparam int STB_ENTRY = 1;
    localparam int STB_EXTCHG = 2;
    localparam int STB_SETTLED = 3;
    localparam int STB_SWEEP = 4;
    localparam int STB_ERROR = 5;
    localparam int STB_RQS = 6;
    localparam int STB_SWPAR = 7;
    localparam int EXT_SELFTEST = 0;
    localparam int EXT_FMOVER = 1;
    localparam int EXT_EXTREF = 3;
    localparam int EXT_LOCKLOST = 4;
    localparam int EXT_POWERFAIL = 5;
    localparam int EXT_LEVELFAULT = 6;
    localparam logic [7:0] EXT_LIVE_MASK = 8'h7b;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int CLK_HZ = 50000000;
    localparam int SETTLE_MS = 2000;
    localparam longint SETTLE_CYC = longint'(CLK_HZ) * SETTLE_MS / 1000;
    typedef enum logic [1:0] {SSP_IDLE, SSP_SEND_STB, SSP_SEND_EXT}
        ssp_os_e;
endpackage : ssp_pkg

// ### hdl/ssp_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q;
    if (WIDTH < 1) begin : gBadWidth
        $error("width must be positive");
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level <= '0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Change counts only once stages two and three agree
            level <= (s2_q == s3_q) ? s3_q : level;
        end
    end
    assign rise = (s2_q & s3_q) & ~level;
endmodule : ssp_pin_sync
`default_nettype wire

// ### hdl/ssp_settle_timer.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_settle_timer #(
    parameter longint CYCLES = ssp_pkg::SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic valid
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;
    if (CYCLES < 1) begin : gBadCount
        $error("settle count must be positive");
    end
    always_ff @(posedge clk) begin
        if (rst || start) begin
            cnt_q <= W'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    assign valid = (cnt_q == '0) && !start && !rst;
endmodule : ssp_settle_timer
`default_nettype wire

// ### tb/ssp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_ctrl_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic clrCount,
    input wire logic talkValid,
    input wire logic [7:0] talkData,
    output logic talkReady,
    output logic [1:0] rxCount,
    output logic [7:0] rxFirst,
    output logic [7:0] rxSecond
);
    logic stall_q;

    // Alternate stalls so the talker must hold its byte
    always_ff @(posedge clk) begin
        if (rst) begin
            stall_q <= 1'b0;
        end else begin
            stall_q <= slow & ~stall_q;
        end
    end

    assign talkReady = ~stall_q;

    // Raw binary take; a terminator-like value never ends it early
    always_ff @(posedge clk) begin
        if (rst || clrCount) begin
            rxCount <= 2'h0;
        end else if (talkValid && talkReady) begin
            if (rxCount == 2'h0) begin
                rxFirst <= talkData;
            end else begin
                rxSecond <= talkData;
            end
            rxCount <= rxCount + 2'h1;
        end
    end
endmodule : ssp_ctrl_model
`default_nettype wire

// ### tb/tb_ssp_status_unit.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ssp_status_unit;
    logic clk, rst, ifcClear, devClear, clearStatusCmd, outputStatusCmd;
    logic maskOutputCmd, maskSetStrobe, messageReadDone, programString;
    logic presetCmd, settlePending, talkReady, talkValid, serialPollRead;
    logic parallelPoll, ppSense, ppEnable, rfOffPin, srqOut, srqOe_n;
    logic srqLamp, extValid, slow, clrCount;
    logic [7:0] maskSetValue, talkData, pollByte, ppDataOut, ppDataOe_n;
    logic [7:0] stbCondPin, extCondPin, statusByte, extendedStatusByte;
    logic [7:0] rxFirst, rxSecond;
    logic [2:0] ppLine;
    logic [1:0] rxCount;
    int miscompares = 0;
    int testsRun = 0;

    ssp_status_unit #(.SETTLE_CYCLES(20)) i_ssp_status_unit (
        .clk(clk), .rst(rst), .ifcClear(ifcClear), .devClear(devClear),
        .clearStatusCmd(clearStatusCmd), .outputStatusCmd(outputStatusCmd),
        .maskOutputCmd(maskOutputCmd), .maskSetStrobe(maskSetStrobe),
        .maskSetValue(maskSetValue), .messageReadDone(messageReadDone),
        .programString(programString), .presetCmd(presetCmd),
        .settlePending(settlePending), .talkReady(talkReady),
        .talkValid(talkValid), .talkData(talkData),
        .serialPollRead(serialPollRead), .pollByte(pollByte),
        .parallelPoll(parallelPoll), .ppLine(ppLine), .ppSense(ppSense),
        .ppEnable(ppEnable), .ppDataOut(ppDataOut), .ppDataOe_n(ppDataOe_n),
        .stbCondPin(stbCondPin), .extCondPin(extCondPin),
        .rfOffPin(rfOffPin), .srqOut(srqOut), .srqOe_n(srqOe_n),
        .srqLamp(srqLamp), .extValid(extValid), .statusByte(statusByte),
        .extendedStatusByte(extendedStatusByte));

    ssp_ctrl_model i_ssp_ctrl_model (
        .clk(clk), .rst(rst), .slow(slow), .clrCount(clrCount),
        .talkValid(talkValid), .talkData(talkData), .talkReady(talkReady),
        .rxCount(rxCount), .rxFirst(rxFirst), .rxSecond(rxSecond));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask : pulse

    // Pins pass a 3-flop sync, so hold each level for several cycles
    task automatic cond(input logic [7:0] s, input logic rf);
        stbCondPin = s;
        rfOffPin = rf;
        cyc(6);
        stbCondPin = 8'h00;
        rfOffPin = 1'b0;
        cyc(6);
    endtask : cond

    task automatic talk(ref logic cmd, input int n);
        int k;
        k = 0;
        clrCount = 1'b1;
        cyc(1);
        clrCount = 1'b0;
        pulse(cmd);
        while (rxCount !== n[1:0] && k < 50) begin
            cyc(1);
            k++;
        end
        if (k == 50) begin
            miscompares++;
            final_report();
        end
        cyc(2);
    endtask : talk

    task automatic maskSet(input logic [7:0] v);
        maskSetValue = v;
        pulse(maskSetStrobe);
    endtask : maskSet

    initial begin
        {ifcClear, devClear, clearStatusCmd, outputStatusCmd} = 4'h0;
        {maskOutputCmd, maskSetStrobe, messageReadDone, programString} = 4'h0;
        {presetCmd, settlePending, serialPollRead, parallelPoll} = 4'h0;
        {ppSense, ppEnable, rfOffPin, slow, clrCount} = 5'h00;
        {maskSetValue, stbCondPin, extCondPin} = 24'h000000;
        ppLine = 3'h0;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(2);
        chk(statusByte, 8'h00);
        talk(maskOutputCmd, 1);
        chk(rxFirst, 8'h00);
        maskSet(8'h10);
        talk(maskOutputCmd, 1);
        chk(rxFirst, 8'h10);
        cond(8'h01, 1'b0);
        chk(statusByte, 8'h01);
        chk({7'h00, srqOe_n}, 8'h01);
        cond(8'h10, 1'b0);
        chk(statusByte, 8'h51);
        chk({6'h00, srqOe_n, srqLamp}, 8'h01);
        cond(8'h02, 1'b0);
        chk(pollByte, 8'h51);
        // Every line with positive sense while the request stands
        parallelPoll = 1'b1;
        ppEnable = 1'b1;
        ppSense = 1'b1;
        for (int l = 0; l < 8; l++) begin
            ppLine = 3'(l);
            cyc(1);
            chk(ppDataOe_n, ~(8'h01 << l));
            chk(ppDataOut, 8'h00);
        end
        ppSense = 1'b0;
        cyc(1);
        chk(ppDataOe_n, 8'h7f);
        chk(ppDataOut, 8'hff);
        parallelPoll = 1'b0;
        pulse(serialPollRead);
        cyc(3);
        chk(statusByte, 8'h53);
        chk(pollByte, 8'h53);
        cond(8'h00, 1'b1);
        chk(extendedStatusByte, 8'h50);
        chk(statusByte, 8'h57);
        slow = 1'b1;
        talk(outputStatusCmd, 2);
        slow = 1'b0;
        chk(rxFirst, 8'h57);
        chk(rxSecond, 8'h50);
        chk(statusByte, 8'h00);
        chk(extendedStatusByte, 8'h00);
        chk({7'h00, srqOe_n}, 8'h01);
        parallelPoll = 1'b1;
        cyc(1);
        chk(ppDataOe_n, 8'hff);
        parallelPoll = 1'b0;
        chk({7'h00, srqOut}, 8'h00);
        cond(8'h00, 1'b1);
        pulse(clearStatusCmd);
        cyc(2);
        chk(extendedStatusByte, 8'h00);
        chk(statusByte, 8'h04);
        pulse(clearStatusCmd);
        cyc(2);
        chk(statusByte, 8'h00);
        extCondPin = 8'hff;
        cyc(6);
        extCondPin = 8'h00;
        cyc(6);
        chk(extendedStatusByte, 8'h7b);
        pulse(clearStatusCmd);
        chk(statusByte, 8'h04);
        pulse(clearStatusCmd);
        chk(statusByte, 8'h00);
        settlePending = 1'b1;
        pulse(clearStatusCmd);
        cyc(2);
        chk(statusByte, 8'h08);
        settlePending = 1'b0;
        pulse(clearStatusCmd);
        pulse(presetCmd);
        chk(statusByte, 8'h08);
        cond(8'h20, 1'b0);
        pulse(clearStatusCmd);
        pulse(programString);
        chk(statusByte, 8'h20);
        pulse(messageReadDone);
        pulse(clearStatusCmd);
        pulse(programString);
        chk(statusByte, 8'h00);
        pulse(presetCmd);
        talk(maskOutputCmd, 1);
        chk(rxFirst, 8'h10);
        pulse(ifcClear);
        talk(maskOutputCmd, 1);
        chk(rxFirst, 8'h00);
        maskSet(8'h10);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(2);
        chk({7'h00, srqOe_n}, 8'h01);
        talk(maskOutputCmd, 1);
        chk(rxFirst, 8'h00);
        pulse(devClear);
        chk({7'h00, extValid}, 8'h00);
        cyc(30);
        chk({7'h00, extValid}, 8'h01);
        final_report();
    end
endmodule : tb_ssp_status_unit
`default_nettype wire
